// ### common/scps_pkg.sv
// Function
// - modes 0 and 4: receive clock pin clocks only the receiver
// - modes 1 and 5: receive clock pin clocks receiver and transmitter
// - modes 2 and 3: receive clock pin feeds the baud rate generator
// - transmit clock pin is input when output enable is 0, output when 1
// - input pin, source select clear, modes 0,2,4,6: pin is the transmit clock
// - mode 1 with input pin: pin is a transmit strobe, not a clock
// - output pin, source select set, modes 2,3,6,7: pin carries generator output
// - output pin, source select clear, modes 3,7: pin carries recovered clock
// - output pin, mode 5 with slot tristate enable: pin low in slot, high otherwise
// - transmit data pin is push-pull or open-drain per channel
// - bus configuration: open-drain one sent while sense reads zero flags collision
package scps_pkg;

  localparam int SCPS_NCH = 4;
  localparam int SCPS_AW = 8;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [SCPS_AW-1:0] SCPS_OFF_CFG = 8'h00;
  localparam logic [SCPS_AW-1:0] SCPS_OFF_STAT = 8'h10;
  localparam logic [SCPS_AW-1:0] SCPS_OFF_BRG = 8'h20;
  localparam logic [SCPS_AW-1:0] SCPS_BANK_MASK = 8'hF0;
  localparam logic [SCPS_AW-1:0] SCPS_SLOT_MASK = 8'h0F;
  localparam int SCPS_STAT_COLL = 0;
  localparam int SCPS_BRG_W = 16;
  localparam logic [SCPS_BRG_W-1:0] SCPS_BRG_RST = 16'h0001;
  localparam logic [7:0] SCPS_CFG_RST = 8'h00;

  // ----------------------------------------
  // clock mode decode masks, bit n = mode n
  // ----------------------------------------
  localparam logic [7:0] SCPS_M_RX_PIN = 8'h33;
  localparam logic [7:0] SCPS_M_TX_FROM_RX = 8'h22;
  localparam logic [7:0] SCPS_M_BRG_PIN = 8'h0C;
  localparam logic [7:0] SCPS_M_TXIN_CLK = 8'h55;
  localparam logic [7:0] SCPS_M_STROBE = 8'h02;
  localparam logic [7:0] SCPS_M_BRG_OUT = 8'hCC;
  localparam logic [7:0] SCPS_M_DPLL_OUT = 8'h88;
  localparam logic [7:0] SCPS_M_SLOT = 8'h20;

  // config word, bit 7 down to bit 0
  typedef struct packed {
    logic bus;
    logic od;
    logic tte;
    logic toe;
    logic ssel;
    logic [2:0] mode;
  } scps_cfg_s;

  typedef struct packed {
    logic line_receive_clock_pin;
    logic line_transmit_clock_pin_i;
    logic collision_sense_input;
  } scps_line_in_s;

  typedef struct packed {
    logic line_transmit_clock_pin_o;
    logic line_transmit_clock_pin_oe;
    logic txd_o;
    logic txd_oe;
  } scps_line_out_s;

  typedef struct packed {
    logic tx_data;
    logic dpll_clk;
    logic slot_active;
  } scps_core_in_s;

  typedef struct packed {
    logic rx_clk;
    logic tx_clk;
    logic tx_strobe;
    logic brg_clk;
  } scps_core_out_s;

  typedef enum logic [1:0] {
    SCPS_IDLE = 2'b01,
    SCPS_ACK = 2'b10
  } scps_apb_e;

  function automatic logic scps_mode_hit(input logic [2:0] m, input logic [7:0] mask);
    return mask[m];
  endfunction

endpackage

// ### rtl/scps_brg.sv
`timescale 1ns/1ps
module scps_brg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic use_pin,
  input wire logic pin_clk,
  input wire logic [scps_pkg::SCPS_BRG_W-1:0] divisor,
  output logic brg_out
);
  import scps_pkg::*;

  logic pin_d_r, pin_d_nxt;
  logic [SCPS_BRG_W-1:0] cnt_r, cnt_nxt;
  logic out_r, out_nxt;
  logic tick;

  // ----------------------------------------
  // divide pclk or pin edges, toggle output
  // ----------------------------------------
  always_comb begin
    pin_d_nxt = pin_clk;
    tick = use_pin ? (pin_clk & ~pin_d_r) : 1'b1;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (tick) begin
      if (cnt_r + 1'b1 >= divisor) begin
        cnt_nxt = '0;
        out_nxt = ~out_r;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r <= 1'b0;
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      pin_d_r <= pin_d_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign brg_out = out_r;

endmodule // scps_brg

// ### rtl/scps_route.sv
`timescale 1ns/1ps
module scps_route (
  input wire logic pclk,
  input wire logic presetn,
  input wire scps_pkg::scps_cfg_s cfg,
  input wire scps_pkg::scps_line_in_s line_i,
  input wire scps_pkg::scps_core_in_s core_i,
  input wire logic brg_out,
  output scps_pkg::scps_line_out_s line_o,
  output scps_pkg::scps_core_out_s core_o,
  output logic coll_evt
);
  import scps_pkg::*;

  scps_line_out_s line_r, line_nxt;
  scps_core_out_s core_r, core_nxt;
  logic coll_r, coll_nxt;

  // ----------------------------------------
  // pin and clock routing
  // ----------------------------------------
  always_comb begin
    core_nxt.rx_clk = scps_mode_hit(cfg.mode, SCPS_M_RX_PIN) ? line_i.line_receive_clock_pin : brg_out;
    core_nxt.brg_clk = scps_mode_hit(cfg.mode, SCPS_M_BRG_PIN) ? line_i.line_receive_clock_pin : 1'b0;
    if (scps_mode_hit(cfg.mode, SCPS_M_TX_FROM_RX))
      core_nxt.tx_clk = line_i.line_receive_clock_pin;
    else if (!cfg.toe && !cfg.ssel && scps_mode_hit(cfg.mode, SCPS_M_TXIN_CLK))
      core_nxt.tx_clk = line_i.line_transmit_clock_pin_i;
    else if (cfg.toe && !cfg.ssel && scps_mode_hit(cfg.mode, SCPS_M_DPLL_OUT))
      core_nxt.tx_clk = core_i.dpll_clk;
    else
      core_nxt.tx_clk = brg_out;
    core_nxt.tx_strobe = (!cfg.toe && scps_mode_hit(cfg.mode, SCPS_M_STROBE)) ? line_i.line_transmit_clock_pin_i : 1'b1;
    line_nxt.line_transmit_clock_pin_oe = cfg.toe;
    if (cfg.tte && scps_mode_hit(cfg.mode, SCPS_M_SLOT))
      line_nxt.line_transmit_clock_pin_o = ~core_i.slot_active;
    else if (cfg.ssel && scps_mode_hit(cfg.mode, SCPS_M_BRG_OUT))
      line_nxt.line_transmit_clock_pin_o = brg_out;
    else if (!cfg.ssel && scps_mode_hit(cfg.mode, SCPS_M_DPLL_OUT))
      line_nxt.line_transmit_clock_pin_o = core_i.dpll_clk;
    else
      line_nxt.line_transmit_clock_pin_o = brg_out;
    // open drain only ever pulls low
    line_nxt.txd_o = cfg.od ? 1'b0 : core_i.tx_data;
    line_nxt.txd_oe = cfg.od ? ~core_i.tx_data : 1'b1;
    coll_nxt = cfg.bus && cfg.od && core_i.tx_data && !line_i.collision_sense_input;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r <= '{line_transmit_clock_pin_o: 1'b0, line_transmit_clock_pin_oe: 1'b0, txd_o: 1'b1, txd_oe: 1'b0};
      core_r <= '{rx_clk: 1'b0, tx_clk: 1'b0, tx_strobe: 1'b1, brg_clk: 1'b0};
      coll_r <= 1'b0;
    end else begin
      line_r <= line_nxt;
      core_r <= core_nxt;
      coll_r <= coll_nxt;
    end
  end

  assign line_o = line_r;
  assign core_o = core_r;
  assign coll_evt = coll_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_rx_pin_clock: assert property (@(posedge pclk) disable iff (!presetn)
    scps_mode_hit(cfg.mode, SCPS_M_RX_PIN) |=> core_o.rx_clk == $past(line_i.line_receive_clock_pin))
    else $error("receiver clock not from receive pin");
  a_rxtx_shared: assert property (@(posedge pclk) disable iff (!presetn)
    scps_mode_hit(cfg.mode, SCPS_M_TX_FROM_RX) |=> core_o.tx_clk == $past(line_i.line_receive_clock_pin))
    else $error("transmit clock not from receive pin");
  a_brg_pin_in: assert property (@(posedge pclk) disable iff (!presetn)
    scps_mode_hit(cfg.mode, SCPS_M_BRG_PIN) |=> core_o.brg_clk == $past(line_i.line_receive_clock_pin))
    else $error("generator input not from receive pin");
  a_line_transmit_clock_pin_dir: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 line_o.line_transmit_clock_pin_oe == $past(cfg.toe))
    else $error("transmit clock pin direction wrong");
  a_txin_clock: assert property (@(posedge pclk) disable iff (!presetn)
    (!cfg.toe && !cfg.ssel && scps_mode_hit(cfg.mode, SCPS_M_TXIN_CLK)) |=> core_o.tx_clk == $past(line_i.line_transmit_clock_pin_i))
    else $error("transmit clock not from transmit pin");
  a_strobe_use: assert property (@(posedge pclk) disable iff (!presetn)
    (!cfg.toe && cfg.mode == 3'd1) |=> core_o.tx_strobe == $past(line_i.line_transmit_clock_pin_i) && core_o.tx_clk == $past(line_i.line_receive_clock_pin))
    else $error("strobe not taken from transmit pin");
  a_brg_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.toe && cfg.ssel && scps_mode_hit(cfg.mode, SCPS_M_BRG_OUT) && !(cfg.tte && cfg.mode == 3'd5))
    |=> line_o.line_transmit_clock_pin_o == $past(brg_out) && line_o.line_transmit_clock_pin_oe)
    else $error("pin not driven by generator");
  a_dpll_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.toe && !cfg.ssel && scps_mode_hit(cfg.mode, SCPS_M_DPLL_OUT)) |=> line_o.line_transmit_clock_pin_o == $past(core_i.dpll_clk))
    else $error("pin not driven by recovered clock");
  a_slot_mark: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.tte && cfg.mode == 3'd5) |=> line_o.line_transmit_clock_pin_o != $past(core_i.slot_active))
    else $error("slot marker polarity wrong");
  a_od_no_high: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.od |=> !(line_o.txd_oe && line_o.txd_o) && line_o.txd_oe == !$past(core_i.tx_data))
    else $error("open drain drove high");
  a_coll_detect: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.bus && cfg.od && core_i.tx_data && !line_i.collision_sense_input) |=> coll_evt)
    else $error("collision missed");

endmodule // scps_route

// ### rtl/scps_top.sv
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module scps_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scps_pkg::SCPS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scps_pkg::scps_line_in_s [scps_pkg::SCPS_NCH-1:0] line_i,
  input wire scps_pkg::scps_core_in_s [scps_pkg::SCPS_NCH-1:0] core_i,
  output scps_pkg::scps_line_out_s [scps_pkg::SCPS_NCH-1:0] line_o,
  output scps_pkg::scps_core_out_s [scps_pkg::SCPS_NCH-1:0] core_o
);
  import scps_pkg::*;

  scps_apb_e st_r, st_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  scps_cfg_s [SCPS_NCH-1:0] cfg_r, cfg_nxt;
  logic [SCPS_NCH-1:0][SCPS_BRG_W-1:0] div_r, div_nxt;
  logic [SCPS_NCH-1:0] coll_r, coll_nxt;
  logic [SCPS_NCH-1:0] coll_evt;
  logic [SCPS_NCH-1:0] brg_out;
  logic wr_go;
  logic [1:0] ch;
  logic hit;

  // ----------------------------------------
  // apb slave, one wait-free access cycle
  // ----------------------------------------
  assign ch = paddr[3:2];
  assign hit = ((paddr & SCPS_SLOT_MASK) < SCPS_AW'(SCPS_NCH * 4)) && (paddr[1:0] == 2'b00) &&
               ((paddr & SCPS_BANK_MASK) <= SCPS_OFF_BRG);
  assign wr_go = psel && penable && pready_r && pwrite && hit;

  always_comb begin
    st_nxt = st_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    case (st_r)
      SCPS_IDLE: begin
        if (psel && !penable) begin
          st_nxt = SCPS_ACK;
          pready_nxt = 1'b1;
          pslverr_nxt = !hit;
          prdata_nxt = '0;
          if (hit && !pwrite) begin
            case (paddr & SCPS_BANK_MASK)
              SCPS_OFF_CFG: prdata_nxt = 32'(cfg_r[ch]);
              SCPS_OFF_STAT: prdata_nxt = 32'(coll_r[ch]) << SCPS_STAT_COLL;
              SCPS_OFF_BRG: prdata_nxt = 32'(div_r[ch]);
              default: prdata_nxt = '0;
            endcase
          end
        end
      end
      SCPS_ACK: begin
        st_nxt = SCPS_IDLE;
      end
      default: begin
        st_nxt = SCPS_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // channel registers
  // ----------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    div_nxt = div_r;
    for (int i = 0; i < SCPS_NCH; i++) begin
      // event set beats software clear
      coll_nxt[i] = coll_evt[i] | coll_r[i];
      if (wr_go && ch == 2'(i)) begin
        case (paddr & SCPS_BANK_MASK)
          SCPS_OFF_CFG: cfg_nxt[i] = scps_cfg_s'(pwdata[7:0]);
          SCPS_OFF_STAT: coll_nxt[i] = coll_evt[i] | (coll_r[i] & ~pwdata[SCPS_STAT_COLL]);
          SCPS_OFF_BRG: div_nxt[i] = pwdata[SCPS_BRG_W-1:0];
          default: cfg_nxt[i] = cfg_r[i];
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= SCPS_IDLE;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      cfg_r <= {SCPS_NCH{SCPS_CFG_RST}};
      div_r <= {SCPS_NCH{SCPS_BRG_RST}};
      coll_r <= '0;
    end else begin
      st_r <= st_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      cfg_r <= cfg_nxt;
      div_r <= div_nxt;
      coll_r <= coll_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------
  // per channel generator and routing
  // ----------------------------------------
  for (genvar g = 0; g < SCPS_NCH; g++) begin : g_ch
    scps_brg u_brg (
      .pclk(pclk),
      .presetn(presetn),
      .use_pin(scps_mode_hit(cfg_r[g].mode, SCPS_M_BRG_PIN)),
      .pin_clk(line_i[g].line_receive_clock_pin),
      .divisor(div_r[g]),
      .brg_out(brg_out[g])
    );
    scps_route u_route (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg_r[g]),
      .line_i(line_i[g]),
      .core_i(core_i[g]),
      .brg_out(brg_out[g]),
      .line_o(line_o[g]),
      .core_o(core_o[g]),
      .coll_evt(coll_evt[g])
    );
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_coll_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    coll_evt[0] |=> coll_r[0])
    else $error("collision event lost");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && st_r == SCPS_IDLE) |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule // scps_top

// ### bench/scps_line_model.sv
`timescale 1ns/1ps
module scps_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_run,
  input wire logic [3:0] rx_half,
  input wire logic [3:0] jam,
  input wire logic [3:0] tx_src,
  input wire scps_pkg::scps_line_out_s [scps_pkg::SCPS_NCH-1:0] line_o,
  output scps_pkg::scps_line_in_s [scps_pkg::SCPS_NCH-1:0] line_i
);
  import scps_pkg::*;
  logic [3:0] cnt_r;
  logic rx_r;
  // line clock stands still while rx_run is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      rx_r <= 1'b0;
    end else if (rx_run) begin
      cnt_r <= (cnt_r >= rx_half - 4'h1) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r >= rx_half - 4'h1) rx_r <= ~rx_r;
    end
  end
  always_comb begin
    for (int i = 0; i < SCPS_NCH; i++) begin
      line_i[i].line_receive_clock_pin = rx_r;
      line_i[i].line_transmit_clock_pin_i = line_o[i].line_transmit_clock_pin_oe ? line_o[i].line_transmit_clock_pin_o : tx_src[i];
      line_i[i].collision_sense_input = ~jam[i] & (line_o[i].txd_oe ? line_o[i].txd_o : 1'b1);
    end
  end
endmodule  // scps_line_model

// ### bench/scps_top_tb.sv
`timescale 1ns/1ps
module scps_top_tb;
  import scps_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_run, err;
  logic [SCPS_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [3:0] rx_half, jam, tx_src;
  scps_line_in_s [SCPS_NCH-1:0] line_i;
  scps_core_in_s [SCPS_NCH-1:0] core_i;
  scps_line_out_s [SCPS_NCH-1:0] line_o;
  scps_core_out_s [SCPS_NCH-1:0] core_o;
  scps_cfg_s cfg [SCPS_NCH];
  int errors, checked, seed;

  scps_top u_scps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_i(line_i), .core_i(core_i), .line_o(line_o), .core_o(core_o));
  scps_line_model u_scps_line_model (.pclk(pclk), .presetn(presetn), .rx_run(rx_run), .rx_half(rx_half),
    .jam(jam), .tx_src(tx_src), .line_o(line_o), .line_i(line_i));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [SCPS_AW-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      $display("[ERR] pready expected 1 seen timeout");
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // bits: rx_clk tx_clk tx_strobe line_transmit_clock_pin_oe line_transmit_clock_pin_o txd_o txd_oe
  function automatic logic [6:0] expv(input scps_cfg_s c, input scps_line_in_s li, input scps_core_in_s ci,
      output logic [6:0] k);
    logic [7:0] m;
    logic [6:0] v;
    m = 8'h01 << c.mode;
    v = '0;
    k = 7'h7F;
    v[6] = li.line_receive_clock_pin;
    k[6] = |(m & 8'h33);
    if (|(m & 8'h22)) v[5] = li.line_receive_clock_pin;
    else if (!c.toe && !c.ssel && |(m & 8'h55)) v[5] = li.line_transmit_clock_pin_i;
    else if (c.toe && !c.ssel && |(m & 8'h88)) v[5] = ci.dpll_clk;
    else k[5] = 1'b0;
    v[4] = (c.mode == 3'd1 && !c.toe) ? li.line_transmit_clock_pin_i : 1'b1;
    v[3] = c.toe;
    if (c.mode == 3'd5 && c.tte) v[2] = ~ci.slot_active;
    else if (!c.ssel && |(m & 8'h88)) v[2] = ci.dpll_clk;
    else k[2] = 1'b0;
    v[1] = c.od ? 1'b0 : ci.tx_data;
    v[0] = c.od ? ~ci.tx_data : 1'b1;
    return v;
  endfunction

  task automatic route(input int cycles);
    scps_line_in_s [SCPS_NCH-1:0] li;
    scps_core_in_s [SCPS_NCH-1:0] ci;
    logic [6:0] v, k, g;
    for (int t = 0; t < cycles; t++) begin
      @(posedge pclk);
      li = line_i;
      ci = core_i;
      rnd = $random(seed);
      core_i <= rnd[11:0];
      tx_src <= rnd[15:12];
      #1;
      for (int i = 0; i < SCPS_NCH; i++) begin
        v = expv(cfg[i], li[i], ci[i], k);
        g = {core_o[i].rx_clk, core_o[i].tx_clk, core_o[i].tx_strobe, line_o[i].line_transmit_clock_pin_oe,
          line_o[i].line_transmit_clock_pin_o, line_o[i].txd_o, line_o[i].txd_oe};
        chk("route", v & k, g & k);
        chk("brg_clk", li[i].line_receive_clock_pin && (cfg[i].mode == 3'd2 || cfg[i].mode == 3'd3), core_o[i].brg_clk);
      end
    end
    @(posedge pclk);
  endtask

  task automatic count(input int lo, input int hi);
    int n;
    logic p;
    n = 0;
    p = line_o[3].line_transmit_clock_pin_o;
    repeat (64) begin
      @(posedge pclk);
      if (line_o[3].line_transmit_clock_pin_o !== p) n++;
      p = line_o[3].line_transmit_clock_pin_o;
    end
    chk("brg_toggles", 32'h1, (n >= lo && n <= hi));
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    seed = 32'h135d84df;
    errors = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    core_i = '0;
    jam = 4'h0;
    tx_src = 4'h0;
    rx_run = 1'b1;
    rx_half = 4'h3;
    repeat (5) @(posedge pclk);
    chk("reset_line", 32'h2, line_o[0]);
    chk("reset_core", 32'h2, core_o[0]);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SCPS_OFF_CFG, 32'h0);
    chk("cfg_reset", 32'h0, rd);
    apb(1'b0, SCPS_OFF_BRG + 8'h04, 32'h0);
    chk("brg_reset", 32'h1, rd);
    apb(1'b1, SCPS_OFF_CFG + 8'h08, 32'hFFFFFFA5);
    apb(1'b0, SCPS_OFF_CFG + 8'h08, 32'h0);
    chk("cfg_rw", 32'hA5, rd);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped_err", 32'h1, err);
    apb(1'b0, 8'h02, 32'h0);
    chk("misaligned_err", 32'h1, err);
    $display("test registers done");
    for (int it = 0; it < 40; it++) begin
      for (int i = 0; i < SCPS_NCH; i++) begin
        rnd = $random(seed);
        cfg[i] = rnd[7:0];
        cfg[i].mode = 3'(it + i);
        apb(1'b1, SCPS_OFF_CFG + 8'(4 * i), {24'h0, cfg[i]});
      end
      route(12);
    end
    $display("test routing done");
    // data high first, so the switch to open drain raises no collision
    core_i <= {4{3'b100}};
    apb(1'b1, SCPS_OFF_CFG, 32'hC0);
    apb(1'b1, SCPS_OFF_CFG + 8'h04, 32'h40);
    apb(1'b1, SCPS_OFF_STAT, 32'h1);
    apb(1'b1, SCPS_OFF_STAT + 8'h04, 32'h1);
    jam <= 4'h3;
    repeat (3) @(posedge pclk);
    jam <= 4'h0;
    repeat (3) @(posedge pclk);
    apb(1'b0, SCPS_OFF_STAT, 32'h0);
    chk("coll_bus", 32'h1, rd);
    apb(1'b0, SCPS_OFF_STAT + 8'h04, 32'h0);
    chk("coll_nobus", 32'h0, rd);
    apb(1'b1, SCPS_OFF_STAT, 32'h1);
    apb(1'b0, SCPS_OFF_STAT, 32'h0);
    chk("coll_clear", 32'h0, rd);
    $display("test collision done");
    rx_run <= 1'b0;
    rx_half <= 4'h2;
    apb(1'b1, SCPS_OFF_BRG + 8'h0C, 32'h2);
    apb(1'b1, SCPS_OFF_CFG + 8'h0C, 32'h1A);
    count(0, 0);
    rx_run <= 1'b1;
    count(7, 9);
    apb(1'b1, SCPS_OFF_BRG + 8'h0C, 32'h4);
    apb(1'b1, SCPS_OFF_CFG + 8'h0C, 32'h1E);
    count(15, 17);
    $display("test generator done");
    // reset in mid-run: pins and registers back to their reset state
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("reset_mid_line", 32'h2, line_o[3]);
    chk("reset_mid_core", 32'h2, core_o[3]);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SCPS_OFF_CFG + 8'h0C, 32'h0);
    chk("cfg_mid_reset", 32'h0, rd);
    apb(1'b0, SCPS_OFF_BRG + 8'h0C, 32'h0);
    chk("brg_mid_reset", 32'h1, rd);
    $display("test reset done");
    wrap_up();
  end
endmodule  // scps_top_tb
